// [dv/spisd_monitor.sv]
// checker of bus timing, interrupt level and serial pin behaviour
`timescale 1ns/1ns
module spisd_monitor (
    input wire core_clk,
    input wire nrst,
    input wire clkEn,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitrequest,
    input wire irq,
    input wire sckOut,
    input wire sckOe,
    input wire mosiOe,
    input wire misoOe,
    input wire selIn,
    input wire selOut
);
    // ****************************
    // properties on the top ports
    // ****************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_one_wait; (avsRead || avsWrite) && avsWaitrequest && clkEn |=> !avsWaitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer late");
    property p_wait_req; avsWaitrequest |-> (avsRead || avsWrite); endproperty
    a_wait_req: assert property (p_wait_req) else $error("wait without request");
    property p_rd_upper; avsRead && !avsWaitrequest |-> avsReadData[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    // read data must hold between reads, software sees a stable buffer
    property p_rd_hold; $changed(avsReadData) |-> $past(avsRead); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    // only software clears a flag, so the request can only drop after a write
    property p_irq_fall; $fell(irq) |-> $past(avsWrite); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    property p_sck_half; sckOe && $changed(sckOut) |=> $stable(sckOut); endproperty
    a_sck_half: assert property (p_sck_half) else $error("serial clock half period short");
    property p_oe_pair; (sckOe == mosiOe) && !(sckOe && misoOe); endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("master and slave drivers mixed");
    // idle level follows polarity writes, so those cycles are excluded
    property p_sck_busy; sckOe && $stable(sckOe) && $changed(sckOut) && !$past(avsWrite)
        && !$past(avsWrite, 2) |-> !selOut; endproperty
    a_sck_busy: assert property (p_sck_busy) else $error("clock edge outside transfer");
    property p_miso_sel; misoOe |-> !$past(selIn, 2) || !$past(selIn, 3); endproperty
    a_miso_sel: assert property (p_miso_sel) else $error("slave drives while unselected");
endmodule
bind spisd_top spisd_monitor spisd_monitor_i (.core_clk, .nrst, .clkEn, .avsRead, .avsWrite,
    .avsReadData, .avsWaitrequest, .irq, .sckOut, .sckOe, .mosiOe, .misoOe, .selIn, .selOut);

// [dv/spisd_partner.sv]
// serial slave device model answering the block in master mode
`timescale 1ns/1ns
module spisd_partner (
    input wire sck,
    input wire mosi,
    input wire sel,
    input wire cpol,
    input wire cpha,
    input wire [7:0] txByte,
    output reg miso,
    output reg [7:0] rxByte
);
    // *******************
    // byte shifting
    // *******************
    reg [7:0] rxSh;
    reg [7:0] txSh;
    integer cnt;
    initial begin
        miso = 1'h0;
        rxByte = 8'h00;
        cnt = 0;
    end
    // released line shows the inverse of its last level, never a stale bit
    always @(sel) begin
        if (sel === 1'h0) begin
            txSh = txByte;
            miso = txByte[7];
            cnt = 0;
        end else begin
            miso = ~miso;
        end
    end
    // sample on the edge chosen by polarity and phase, shift on the other
    always @(sck) begin
        if (sel === 1'h0 && sck === ~(cpol ^ cpha)) begin
            rxSh = {rxSh[6:0], mosi};
            cnt = cnt + 1;
            if (cnt == 8) rxByte = rxSh;
        end else if (sel === 1'h0 && cnt > 0) begin
            txSh = txSh << 1;
            miso = txSh[7];
        end
    end
endmodule

// [dv/tb.sv]
// self-checking bench: registers, master and slave bytes, flags and interrupt
`timescale 1ns/1ns
`include "spisd_consts.vh"
module tb;
    // *******************
    // stimulus and wiring
    // *******************
    localparam [7:0] ixCtrl = `SPISD_IDX_CTRL;
    localparam [7:0] ixStat = `SPISD_IDX_STAT;
    localparam [7:0] ixData = `SPISD_IDX_DATA;
    localparam [7:0] ixIen = `SPISD_IDX_IEN;
    localparam [7:0] ixPend = `SPISD_IDX_PEND;
    localparam [7:0] ixMask = `SPISD_IDX_MASK;
    reg core_clk, nrst, clkEn, avsRead, avsWrite, sckDrv, mosiDrv, selDrv;
    reg [9:0] avsAddress;
    reg [31:0] avsWriteData;
    reg [3:0] avsByteEnable;
    reg [7:0] pTx, ctl, rv, b, p;
    wire [31:0] avsReadData;
    wire [7:0] pRx;
    wire avsWaitrequest, irq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selOut, selOe;
    wire pMiso;
    wire sckW = sckOe ? sckOut : sckDrv;
    wire mosiW = mosiOe ? mosiOut : mosiDrv;
    wire misoW = misoOe ? misoOut : pMiso;
    wire selW = selOe ? selOut : selDrv;
    integer num_errors = 0;
    integer check_count = 0;
    integer seed = 40742;
    integer i;
    spisd_top spisd_top_i (.core_clk, .nrst, .clkEn, .avsAddress, .avsRead, .avsWrite,
        .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitrequest, .irq, .sckIn(sckW),
        .sckOut, .sckOe, .mosiIn(mosiW), .mosiOut, .mosiOe, .misoIn(misoW), .misoOut, .misoOe,
        .selIn(selW), .selOut, .selOe);
    spisd_partner spisd_partner_i (.sck(sckW), .mosi(mosiW), .sel(selW), .cpol(ctl[3]),
        .cpha(ctl[2]), .txByte(pTx), .miso(pMiso), .rxByte(pRx));
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // ******************
    // tasks and tests
    // ******************
    function [7:0] rev(input [7:0] x);
        integer k;
        for (k = 0; k < 8; k = k + 1) rev[k] = x[7 - k];
    endfunction
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until waitrequest is seen low at an edge; no latency assumed
    task bus(input rd, input [7:0] idx, input [7:0] wd, output [7:0] q);
        integer n;
        @(posedge core_clk);
        avsAddress <= {idx, 2'h0};
        avsRead <= rd;
        avsWrite <= ~rd;
        avsWriteData <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (avsWaitrequest !== 1'h0 && n < 100);
        if (n >= 100) chk("bus answer", 8'h00, 8'h01);
        q = avsReadData[7:0];
        avsRead <= 1'h0;
        avsWrite <= 1'h0;
    endtask
    task wr(input [7:0] idx, input [7:0] wd);
        bus(1'h0, idx, wd, rv);
    endtask
    task rdc(input string nm, input [7:0] idx, input [7:0] exp);
        bus(1'h1, idx, 8'h00, rv);
        chk(nm, exp, rv);
    endtask
    // flags are level outputs of registers, so look once they have settled
    task chk_irq(input [7:0] exp);
        @(negedge core_clk);
        chk("irq", exp, {7'h0, irq});
    endtask
    task wait_stat(input [7:0] m);
        integer n;
        n = 0;
        rv = 8'h00;
        while ((rv & m) == 8'h00 && n < 400) begin
            bus(1'h1, ixStat, 8'h00, rv);
            n = n + 1;
        end
    endtask
    // master byte; the partner sees wire order, so lsb-first reverses it
    task xfer(input [7:0] bt, input [7:0] pt);
        pTx = ctl[5] ? rev(pt) : pt;
        wr(ixData, bt);
        wait_stat(8'h80);
        chk("partner byte", ctl[5] ? rev(bt) : bt, pRx);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'h0;
        clkEn = 1'h1;
        avsAddress = 10'h0;
        avsRead = 1'h0;
        avsWrite = 1'h0;
        avsWriteData = 32'h0;
        avsByteEnable = 4'h1;
        sckDrv = 1'h0;
        mosiDrv = 1'h0;
        selDrv = 1'h1;
        pTx = 8'h00;
        ctl = 8'h00;
        repeat (6) @(posedge core_clk);
        nrst <= 1'h1;
        repeat (3) @(posedge core_clk);
        rdc("control", ixCtrl, 8'h00);
        rdc("status", ixStat, 8'h00);
        rdc("mask", ixMask, 8'h90);
        rdc("unmapped", 8'h10, 8'h00);
        wr(ixStat, 8'h0f);
        rdc("status", ixStat, 8'h08);
        avsByteEnable <= 4'h0;
        wr(ixIen, 8'h01);
        avsByteEnable <= 4'h1;
        rdc("enable", ixIen, 8'h00);
        $display("test registers done");
        // random modes and bytes; a data write while done must not start anything
        for (i = 0; i < 6; i = i + 1) begin
            ctl = 8'hd0 | (8'($random(seed)) & 8'h2f);
            ctl[0] = ctl[0] | ~ctl[1]; // fastest rate outruns the input synchroniser
            wr(ixCtrl, ctl);
            b = 8'($random(seed));
            p = 8'($random(seed));
            xfer(b, p);
            chk("select enable", 8'h01, {7'h0, selOe});
            rdc("status", ixStat, 8'h88);
            wr(ixData, ~b);
            rdc("data", ixData, p);
            chk("select out", 8'h01, {7'h0, selOut});
            wr(ixStat, 8'h08);
        end
        $display("test random master done");
        ctl = 8'hd1;
        wr(ixCtrl, ctl);
        pTx = 8'h3c;
        wr(ixData, 8'ha5);
        // a frozen block resumes the byte where it stopped
        clkEn <= 1'h0;
        repeat (5) @(posedge core_clk);
        clkEn <= 1'h1;
        wr(ixData, 8'h5a);
        wait_stat(8'h80);
        rdc("status", ixStat, 8'hc8);
        chk("partner byte", 8'ha5, pRx);
        wr(ixStat, 8'h08);
        rdc("status", ixStat, 8'h08);
        xfer(8'h11, 8'h77);
        rdc("status", ixStat, 8'ha8);
        rdc("data", ixData, 8'h3c);
        wr(ixStat, 8'h08);
        xfer(8'h22, 8'h99);
        rdc("status", ixStat, 8'h88);
        rdc("data", ixData, 8'h99);
        wr(ixStat, 8'h08);
        $display("test collision and overrun done");
        wr(ixIen, 8'h01);
        xfer(8'h5a, 8'hc3);
        chk_irq(8'h01);
        wr(ixMask, 8'h00);
        chk_irq(8'h00);
        wr(ixMask, 8'h90);
        chk_irq(8'h01);
        wr(ixPend, 8'h80);
        chk_irq(8'h00);
        rdc("data", ixData, 8'hc3);
        $display("test interrupt done");
        // another master pulls select low while fault detection is on
        wr(ixStat, 8'h00);
        ctl = 8'h50;
        wr(ixCtrl, ctl);
        selDrv <= 1'h0;
        wait_stat(8'h10);
        rdc("status", ixStat, 8'h10);
        rdc("control", ixCtrl, 8'h10);
        chk("clock enable", 8'h00, {7'h0, sckOe});
        chk_irq(8'h01);
        selDrv <= 1'h1;
        wr(ixPend, 8'h10);
        wr(ixStat, 8'h00);
        rdc("status", ixStat, 8'h00);
        rdc("control", ixCtrl, 8'h50);
        chk_irq(8'h00);
        $display("test mode fault done");
        // slave: a data write only preloads; the bench clocks a byte at the link rate
        ctl = 8'h40;
        wr(ixCtrl, ctl);
        wr(ixData, 8'h96);
        p = 8'h4b;
        selDrv <= 1'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            mosiDrv <= p[i];
            repeat (8) @(posedge core_clk);
            b[i] = misoW;
            sckDrv <= 1'h1;
            repeat (8) @(posedge core_clk);
            sckDrv <= 1'h0;
        end
        // let the last clock fall pass the synchroniser before select lifts
        repeat (8) @(posedge core_clk);
        chk("slave clock drive", 8'h00, {7'h0, sckOe});
        selDrv <= 1'h1;
        mosiDrv <= ~mosiDrv;
        wait_stat(8'h80);
        rdc("status", ixStat, 8'h80);
        rdc("data", ixData, p);
        chk("slave sent", 8'h96, b);
        $display("test slave done");
        print_verdict;
    end
    // watchdog: a hang ends the run as a failure
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors = num_errors + 1;
        print_verdict;
    end
endmodule

// [hdl/spisd_consts.vh]
// constants of the serial status and data path block
//
// Overview of operation
// R1: transfer done flag, status bit 7, sets on byte end or buffer load; the code sets it on byte end only.
// R2: done flag rising with serial interrupt enable set raises the interrupt.
// R3: data writes are ignored while done flag set; software clears it.
// R4: write collision sets status bit 6, held until software clears it.
// R5: overrun, status bit 5, sets when byte arrives before previous read.
// R6: no receive buffer load while overrun flag is set.
// R7: mode fault sets status bit 4, held until software clears it.
// R8: writing 0 to collision, fault and done bits clears them.
// R9: status bit 3 is select pin function; bits 2 to 0 reserved.
// R10: one 8-bit data register both sends and receives bytes.
// R11: only a data write starts a transfer, and only in master mode.
// R12: data reads return the receive buffer, never the live shifter.
// R13: software clears the done flag before the next byte lands.
// R14: master select pin role from select function and output enable.
// R15: serial system enable reads 0 while mode fault is set.
// R16: with interrupt enable, done or fault setting requests an interrupt.
// R17: mode fault when master, fault detection on, select input low.
`ifndef SPISD_CONSTS_VH
`define SPISD_CONSTS_VH
// register indices; byte address is four times the index
`define SPISD_IDX_CTRL 8'hf3
`define SPISD_IDX_STAT 8'hf4
`define SPISD_IDX_DATA 8'hf5
`define SPISD_IDX_IEN 8'hf9
`define SPISD_IDX_PEND 8'he0
`define SPISD_IDX_MASK 8'he1
// status and pending bit positions
`define SPISD_ST_DONE 7
`define SPISD_ST_COLL 6
`define SPISD_ST_OVR 5
`define SPISD_ST_FAULT 4
`define SPISD_ST_SELF 3
// control bit positions
`define SPISD_CT_SELOE 7
`define SPISD_CT_SYSEN 6
`define SPISD_CT_LSBF 5
`define SPISD_CT_MSTR 4
`define SPISD_CT_CPOL 3
`define SPISD_CT_CPHA 2
`define SPISD_IEN_BIT 0
// reset values
`define SPISD_RST_CTRL 8'h00
`define SPISD_RST_MASK 8'h90
`define SPISD_RST_BYTE 8'h00
// serial clock half period base, in core clock cycles
`define SPISD_HALF_BASE 5'h02
`endif

// [hdl/spisd_shifter.v]
// byte shift engine for master and slave serial transfers
`timescale 1ns/1ns
module spisd_shifter #(
    parameter DW = 8
) (
    input wire clk,
    input wire rstN,
    input wire ce,
    input wire master,
    input wire cpol,
    input wire cpha,
    input wire lsbFirst,
    input wire [1:0] divSel,
    input wire start,
    input wire load,
    input wire abort,
    input wire [DW-1:0] txByte,
    input wire sckSync,
    input wire selActive,
    input wire dataIn,
    output wire busy,
    output wire done,
    output wire [DW-1:0] rxByte,
    output wire sckOut,
    output wire dataOut
);
`include "spisd_consts.vh"
    localparam integer LAST_EDGE_N = 2 * DW - 1;
    localparam [4:0] LAST_EDGE = LAST_EDGE_N[4:0];

    reg busy_ff;
    reg done_ff;
    reg sckLvl_ff;
    reg sckPrev_ff;
    reg [4:0] divCnt_ff;
    reg [4:0] edgeCnt_ff;
    reg [DW-1:0] txSh_ff;
    reg [DW-1:0] rxSh_ff;
    reg [DW-1:0] rxByte_ff;

    // edge sources: own divider as master, sampled pin as slave
    wire [4:0] halfPer = `SPISD_HALF_BASE << divSel;
    wire mTick = busy_ff & master & (divCnt_ff == halfPer - 5'h01);
    wire sRise = ~master & selActive & sckSync & ~sckPrev_ff;
    wire sFall = ~master & selActive & ~sckSync & sckPrev_ff;
    wire lead = master ? (mTick & ~sckLvl_ff) : (cpol ? sFall : sRise);
    wire trail = master ? (mTick & sckLvl_ff) : (cpol ? sRise : sFall);
    wire anyEdge = lead | trail;
    wire sampleEdge = cpha ? trail : lead;
    // cpha 1 already shows the first bit, so its first shift is skipped
    wire shiftEdge = (cpha ? lead : trail) & ~(cpha & (edgeCnt_ff == 5'h00));
    wire lastEdge = anyEdge & (edgeCnt_ff == LAST_EDGE);
    wire [DW-1:0] rxNext = lsbFirst ? {dataIn, rxSh_ff[DW-1:1]}
                                    : {rxSh_ff[DW-2:0], dataIn};

    // shift state, frozen while the clock enable is low
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            sckLvl_ff <= 1'b0;
            sckPrev_ff <= 1'b0;
            divCnt_ff <= 5'h00;
            edgeCnt_ff <= 5'h00;
            txSh_ff <= {DW{1'b0}};
            rxSh_ff <= {DW{1'b0}};
            rxByte_ff <= {DW{1'b0}};
        end else if (ce) begin
            sckPrev_ff <= sckSync;
            done_ff <= 1'b0;
            if (abort || (!master && !selActive)) begin
                busy_ff <= 1'b0;
                sckLvl_ff <= 1'b0;
                edgeCnt_ff <= 5'h00;
                divCnt_ff <= 5'h00;
                if (load) begin
                    txSh_ff <= txByte;
                end
            end else if (load && !busy_ff) begin
                txSh_ff <= txByte;
                busy_ff <= start; // R11
                divCnt_ff <= 5'h00;
            end else begin
                if (master && busy_ff) begin
                    divCnt_ff <= mTick ? 5'h00 : divCnt_ff + 5'h01;
                end
                if (mTick) begin
                    sckLvl_ff <= ~sckLvl_ff;
                end
                if (sampleEdge) begin
                    rxSh_ff <= rxNext;
                end
                if (shiftEdge) begin
                    txSh_ff <= lsbFirst ? (txSh_ff >> 1) : (txSh_ff << 1);
                end
                if (lastEdge) begin
                    edgeCnt_ff <= 5'h00;
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    rxByte_ff <= sampleEdge ? rxNext : rxSh_ff;
                end else if (anyEdge) begin
                    edgeCnt_ff <= edgeCnt_ff + 5'h01;
                    busy_ff <= 1'b1;
                end
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign rxByte = rxByte_ff;
    assign sckOut = sckLvl_ff ^ cpol;
    assign dataOut = lsbFirst ? txSh_ff[0] : txSh_ff[DW-1];
endmodule

// [hdl/spisd_top.v]
// serial peripheral status flags, data buffer and register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
module spisd_top #(
    parameter DW = 8,
    parameter AW = 10
) (
    input wire core_clk,
    input wire nrst,
    input wire clkEn,
    input wire [AW-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output wire [31:0] avsReadData,
    output wire avsWaitrequest,
    output wire irq,
    input wire sckIn,
    output wire sckOut,
    output wire sckOe,
    input wire mosiIn,
    output wire mosiOut,
    output wire mosiOe,
    input wire misoIn,
    output wire misoOut,
    output wire misoOe,
    input wire selIn,
    output wire selOut,
    output wire selOe
);
`include "spisd_consts.vh"

    // ****************************************
    // reset release
    // ****************************************

    reg rstMeta_ff;
    reg rstSync_ff;

    // assert at once, release after two edges
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    wire rstN = rstSync_ff;

    // ****************************************
    // pin input synchronisers
    // ****************************************

    wire [3:0] pinRaw = {selIn, sckIn, misoIn, mosiIn};
    wire [3:0] pinSync;

    // two flops per pin; only the second one is read
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
            reg meta_ff;
            reg sync_ff;
            always @(posedge core_clk or negedge rstN) begin
                if (!rstN) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                end else if (clkEn) begin
                    meta_ff <= pinRaw[gi];
                    sync_ff <= meta_ff;
                end
            end
            assign pinSync[gi] = sync_ff;
        end
    endgenerate

    wire mosiSync = pinSync[0];
    wire misoSync = pinSync[1];
    wire sckSync = pinSync[2];
    wire selSync = pinSync[3];

    // ****************************************
    // bus slave handshake
    // ****************************************

    reg ack_ff;
    reg [7:0] rdata_ff;

    wire busReq = avsRead | avsWrite;
    wire [7:0] regIdx = avsAddress[AW-1:2];
    wire aligned = (avsAddress[1:0] == 2'b00);
    // one wait cycle: request taken on the edge where ack_ff is high
    wire accept = busReq & ack_ff;
    wire wrLane = avsWrite & accept & avsByteEnable[0];
    wire rdTake = avsRead & accept;

    // ****************************************
    // registers
    // ****************************************

    reg [7:0] ctrl_ff;
    reg selFunc_ff;
    reg ien_ff;
    reg [7:0] mask_ff;
    reg [7:0] pend_ff;
    reg doneFlag_ff;
    reg collFlag_ff;
    reg ovrFlag_ff;
    reg faultFlag_ff;
    reg [DW-1:0] txBuf_ff;
    reg [DW-1:0] rxBuf_ff;
    reg rxUnread_ff;

    wire [7:0] wb = avsWriteData[7:0];
    wire wrCtrl = wrLane & aligned & (regIdx == `SPISD_IDX_CTRL);
    wire wrStat = wrLane & aligned & (regIdx == `SPISD_IDX_STAT);
    wire wrData = wrLane & aligned & (regIdx == `SPISD_IDX_DATA);
    wire wrIen = wrLane & aligned & (regIdx == `SPISD_IDX_IEN);
    wire wrPend = wrLane & aligned & (regIdx == `SPISD_IDX_PEND);
    wire wrMask = wrLane & aligned & (regIdx == `SPISD_IDX_MASK);
    wire rdData = rdTake & aligned & (regIdx == `SPISD_IDX_DATA);

    // control fields
    wire selOutEn = ctrl_ff[`SPISD_CT_SELOE];
    wire sysEn = ctrl_ff[`SPISD_CT_SYSEN];
    wire master = ctrl_ff[`SPISD_CT_MSTR];
    wire cpol = ctrl_ff[`SPISD_CT_CPOL];
    wire cpha = ctrl_ff[`SPISD_CT_CPHA];
    wire lsbFirst = ctrl_ff[`SPISD_CT_LSBF];
    wire [1:0] divSel = ctrl_ff[1:0];
    // a mode fault takes the block down until software clears it
    wire enabled = sysEn & ~faultFlag_ff;

    // ****************************************
    // shift engine and events
    // ****************************************

    wire busy;
    wire xferDone;
    wire [DW-1:0] rxByte;
    wire engSck;
    wire engData;

    // master fault detection only with both select controls low
    wire faultDetect = master & enabled & ~selFunc_ff & ~selOutEn; // R14
    wire faultEvt = faultDetect & ~selSync; // R17
    wire selActive = enabled & ~master & ~selSync;
    // a control change aborts a running master transfer
    wire abort = ~enabled | wrCtrl | faultEvt;

    // data write: ignored while done is set, collides while busy
    wire dataTake = wrData & ~doneFlag_ff & ~busy; // R3
    wire collEvt = wrData & ~doneFlag_ff & busy; // R4
    wire startXfer = dataTake & master & enabled; // R11
    // arrival with the old byte unread is an overrun, never a load
    wire ovrEvt = xferDone & (rxUnread_ff | ovrFlag_ff); // R5
    wire loadRx = xferDone & ~rxUnread_ff & ~ovrFlag_ff; // R6

    spisd_shifter #(
        .DW(DW)
    ) uShifter (
        .clk(core_clk),
        .rstN(rstN),
        .ce(clkEn),
        .master(master),
        .cpol(cpol),
        .cpha(cpha),
        .lsbFirst(lsbFirst),
        .divSel(divSel),
        .start(startXfer),
        .load(dataTake),
        .abort(abort),
        .txByte(wb[DW-1:0]),
        .sckSync(sckSync),
        .selActive(selActive),
        .dataIn(master ? misoSync : mosiSync),
        .busy(busy),
        .done(xferDone),
        .rxByte(rxByte),
        .sckOut(engSck),
        .dataOut(engData)
    );

    // ****************************************
    // status flags
    // ****************************************

    // written 0 clears; a set in the same cycle wins
    wire [7:0] stClr = wrStat ? ~wb : 8'h00;
    wire nxt_doneFlag = xferDone | (doneFlag_ff & ~stClr[`SPISD_ST_DONE]); // R1 R8
    wire nxt_collFlag = collEvt | (collFlag_ff & ~stClr[`SPISD_ST_COLL]); // R4 R8
    wire nxt_ovrFlag = ovrEvt | (ovrFlag_ff & ~stClr[`SPISD_ST_OVR]); // R5
    wire nxt_faultFlag = faultEvt | (faultFlag_ff & ~stClr[`SPISD_ST_FAULT]); // R7 R8

    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            doneFlag_ff <= 1'b0;
            collFlag_ff <= 1'b0;
            ovrFlag_ff <= 1'b0;
            faultFlag_ff <= 1'b0;
            selFunc_ff <= 1'b0;
        end else if (clkEn) begin
            doneFlag_ff <= nxt_doneFlag;
            collFlag_ff <= nxt_collFlag;
            ovrFlag_ff <= nxt_ovrFlag;
            faultFlag_ff <= nxt_faultFlag;
            if (wrStat) begin
                selFunc_ff <= wb[`SPISD_ST_SELF]; // R9
            end
        end
    end

    // ****************************************
    // data buffers
    // ****************************************

    // separate receive buffer so reads never see the live shifter
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            txBuf_ff <= `SPISD_RST_BYTE;
            rxBuf_ff <= `SPISD_RST_BYTE;
            rxUnread_ff <= 1'b0;
        end else if (clkEn) begin
            if (dataTake) begin
                txBuf_ff <= wb[DW-1:0]; // R10
            end
            if (loadRx) begin
                rxBuf_ff <= rxByte; // R12
                rxUnread_ff <= 1'b1;
            end else if (rdData) begin
                rxUnread_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // control and interrupt registers
    // ****************************************

    wire [7:0] evtVec = {xferDone, collEvt, ovrEvt, faultEvt, 4'h0};
    wire [7:0] pendClr = wrPend ? wb : 8'h00;

    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_ff <= `SPISD_RST_CTRL;
            ien_ff <= 1'b0;
            mask_ff <= `SPISD_RST_MASK;
            pend_ff <= 8'h00;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_ff <= wb;
            end
            if (wrIen) begin
                ien_ff <= wb[`SPISD_IEN_BIT];
            end
            if (wrMask) begin
                mask_ff <= wb & 8'hf0;
            end
            // sticky, write one to clear, event wins
            pend_ff <= evtVec | (pend_ff & ~pendClr);
        end
    end

    // level request while any enabled event is pending
    assign irq = ien_ff & (|(pend_ff & mask_ff)); // R2 R16

    // ****************************************
    // read mux and answer
    // ****************************************

    wire [7:0] statRd = {doneFlag_ff, collFlag_ff, ovrFlag_ff,
                         faultFlag_ff, selFunc_ff, 3'b000}; // R9
    // enable reads 0 while a fault stands
    wire [7:0] ctrlRd = {ctrl_ff[7], enabled, ctrl_ff[5:0]}; // R15
    reg [7:0] rdMux;

    always @* begin
        rdMux = 8'h00;
        if (aligned) begin
            case (regIdx)
                `SPISD_IDX_CTRL: rdMux = ctrlRd;
                `SPISD_IDX_STAT: rdMux = statRd;
                `SPISD_IDX_DATA: rdMux = rxBuf_ff; // R12
                `SPISD_IDX_IEN: rdMux = {7'h00, ien_ff};
                `SPISD_IDX_PEND: rdMux = pend_ff;
                `SPISD_IDX_MASK: rdMux = mask_ff;
                default: rdMux = 8'h00;
            endcase
        end
    end

    // data captured in the wait cycle, presented with waitrequest low
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ack_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (clkEn) begin
            ack_ff <= busReq & ~ack_ff;
            if (avsRead && !ack_ff) begin
                rdata_ff <= rdMux;
            end
        end
    end

    assign avsWaitrequest = busReq & ~ack_ff;
    assign avsReadData = {24'h000000, rdata_ff};

    // ****************************************
    // pin drive
    // ****************************************

    wire selOutMode = master & selFunc_ff & selOutEn; // R14

    assign sckOut = master ? engSck : cpol;
    assign sckOe = master & enabled;
    assign mosiOut = engData;
    assign mosiOe = master & enabled;
    assign misoOut = engData;
    // slave drives its output only while selected
    assign misoOe = selActive;
    // low one cycle past the last clock edge, so select never moves with it
    assign selOut = ~(busy | xferDone);
    assign selOe = selOutMode & enabled;

endmodule
